// ===== sfram_chk.sv
// assertion checker for the spi memory slave pins
`include "sfram_defs.svh"
`default_nettype none

module sfram_chk (
  // clocks and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic sck_i,
  // spi pins
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // system side
  input wire logic [7:0] status_o,
  input wire logic update_o
);
  logic [5:0] rise_ff; // honoured sck rises this select cycle
  logic [7:0] opc_ff; // opcode gathered so far
  logic known; // opcode is one of the six
  logic wr_op; // opcode never returns data

  // saturate so a long burst never wraps back into the opcode window
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      rise_ff <= 6'h00;
      opc_ff <= 8'h00;
    end
    else if (hold_n_i && rise_ff != 6'h3f)
    begin
      rise_ff <= rise_ff + 6'h01;
      opc_ff <= (rise_ff < 6'h08) ? {opc_ff[6:0], si_i} : opc_ff;
    end
  end

  assign wr_op = opc_ff inside {`SFRAM_OP_WREN, `SFRAM_OP_WRDI,
    `SFRAM_OP_WRSR, `SFRAM_OP_WRITE};
  assign known = wr_op || opc_ff inside {`SFRAM_OP_READ, `SFRAM_OP_RDSR};

  chk_standby_release: assert property (@(posedge mclk_i)
    cs_n_i |-> so_oe_n_o) else $error("output driven while deselected");
  chk_pause_release: assert property (@(posedge mclk_i)
    !hold_n_i |-> so_oe_n_o) else $error("output driven while paused");
  chk_update_pulse: assert property (@(posedge mclk_i)
    disable iff (srst_i) update_o |=> !update_o)
    else $error("update longer than one cycle");
  chk_status_load: assert property (@(posedge mclk_i)
    disable iff (srst_i) !$stable(status_o) |-> update_o)
    else $error("status changed without update");
  chk_opcode_quiet: assert property (@(posedge sck_i)
    disable iff (cs_n_i) rise_ff < 6'h08 |-> so_oe_n_o)
    else $error("output driven during opcode");
  chk_unknown_quiet: assert property (@(posedge sck_i)
    disable iff (cs_n_i) rise_ff >= 6'h08 && !known |-> so_oe_n_o)
    else $error("output driven after unknown opcode");
  chk_write_quiet: assert property (@(posedge sck_i)
    disable iff (cs_n_i) rise_ff >= 6'h08 && wr_op |-> so_oe_n_o)
    else $error("output driven by a write command");
  chk_read_drive: assert property (@(posedge sck_i)
    disable iff (cs_n_i) hold_n_i && ((opc_ff == `SFRAM_OP_READ &&
    rise_ff >= 6'h18) || (opc_ff == `SFRAM_OP_RDSR && rise_ff >= 6'h08))
    |-> !so_oe_n_o) else $error("read data not driven");
endmodule : sfram_chk

bind sfram_spi_slave sfram_chk i_chk (.mclk_i(mclk_i), .srst_i(srst_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o),
  .so_oe_n_o(so_oe_n_o), .wp_n_i(wp_n_i), .hold_n_i(hold_n_i),
  .status_o(status_o), .update_o(update_o));

`default_nettype wire

// ===== sfram_defs.svh
// constants for the serial nonvolatile memory spi slave front end
// Summary of operation
// - select high: standby, ignore inputs, output released
// - capture on sck rise, shift out on fall
// - fully static, any clock rate, may stop
// - serial input sampled only at sck rise
// - output driven only returning data, not paused
// - protect enable and pin low block status writes
// - pause low freezes transfer, resumes same point
// - byte committed at eighth bit, no busy
// - spi modes zero and three both work
// - block protect quarter, half or whole array
// - write disable rejects writes until re-enabled
// - array is 2048 locations of one byte
// - sck acted on only while select low; status reset still loads on sck rises with select high
// - first byte is opcode, then address, data
// - unknown opcode: ignore rest until next select
// - every byte shifted most significant bit first
// - two address bytes, low eleven bits used
`ifndef SFRAM_DEFS_SVH
`define SFRAM_DEFS_SVH

// array geometry
`define SFRAM_ADDR_W 11
`define SFRAM_DEPTH 2048

// opcode values
`define SFRAM_OP_WREN 8'h06
`define SFRAM_OP_WRDI 8'h04
`define SFRAM_OP_RDSR 8'h05
`define SFRAM_OP_WRSR 8'h01
`define SFRAM_OP_READ 8'h03
`define SFRAM_OP_WRITE 8'h02

// status register field positions
`define SFRAM_SR_PPEN 7
`define SFRAM_SR_BP_HI 3
`define SFRAM_SR_BP_LO 2
`define SFRAM_SR_WEL 1

// status reset value and software writable bits
`define SFRAM_SR_RST 8'h00
`define SFRAM_SR_WMASK 8'h8c

// block protect region bases
`define SFRAM_BASE_QUARTER 11'h600
`define SFRAM_BASE_HALF 11'h400

// block protect codes
`define SFRAM_BP_QUARTER 2'h1
`define SFRAM_BP_HALF 2'h2
`define SFRAM_BP_ALL 2'h3

// bit index of the last bit of a byte
`define SFRAM_BIT_LAST 3'h7

`endif

// ===== sfram_mem.sv
// byte wide array with registered read data
`include "sfram_defs.svh"
`default_nettype none

module sfram_mem (
  // serial clock, the array lives in the link domain
  input wire logic clk_i,
  // array port
  sfram_mem_if.mem port
);

  // storage of 2048 bytes
  logic [7:0] mem_ff [0:`SFRAM_DEPTH-1]; // geometry

  // write commits the moment the strobe is seen
  always_ff @(posedge clk_i)
  begin
    if (port.wr_en)
    begin
      mem_ff[port.wr_addr] <= port.wr_data;
    end
  end

  // read data held between strobes so the shifter can load late
  always_ff @(posedge clk_i)
  begin
    if (port.rd_en)
    begin
      port.rd_data <= mem_ff[port.rd_addr];
    end
  end

endmodule : sfram_mem

`default_nettype wire

// ===== sfram_mem_if.sv
// array port between the link sequencer and the byte memory
`default_nettype none

interface sfram_mem_if;
  logic wr_en; // write strobe, one sck rise
  logic [10:0] wr_addr; // write location
  logic [7:0] wr_data; // byte to commit
  logic rd_en; // read strobe, one sck rise
  logic [10:0] rd_addr; // read location
  logic [7:0] rd_data; // registered read byte

  // sequencer side
  modport ctrl (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_en,
    output rd_addr,
    input rd_data
  );

  // memory side
  modport mem (
    input wr_en,
    input wr_addr,
    input wr_data,
    input rd_en,
    input rd_addr,
    output rd_data
  );
endinterface : sfram_mem_if

`default_nettype wire

// ===== sfram_pkg.sv
// types shared by the spi memory slave modules
`default_nettype none

package sfram_pkg;

  // command sequencer states of the link side
  typedef enum logic [3:0] {
    ST_OPC,
    ST_AHI,
    ST_ALO,
    ST_RD,
    ST_WR,
    ST_SRD,
    ST_SWR,
    ST_DONE,
    ST_IGN
  } sfram_state_t;

endpackage : sfram_pkg

`default_nettype wire

// ===== sfram_spi_master.sv
// spi bus master model driving the memory slave pins
`default_nettype none

module sfram_spi_master (
  // spi pins toward the slave
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  output logic hold_n_o,
  // read data from the slave
  input wire logic so_i,
  input wire logic so_oe_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  bit m3 = 1'b0; // mode 3 when set

  // idle: deselected, clock still, pause released
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end

  // clock idles at the mode's polarity, then select falls
  task sel(input bit mode3);
    m3 = mode3;
    sck_o = mode3;
    #7.5 cs_n_o = 1'b0;
    #7.5;
  endtask : sel

  // park the clock, deselect, and leave junk on the data line
  task desel();
    if (!m3) sck_o = 1'b0;
    #7.5 cs_n_o = 1'b1;
    si_o = ~si_o;
    #15;
  endtask : desel

  // clock pulses with select high, only for the reset sequence
  task dummy(input int n);
    repeat (n)
    begin
      #7.5 sck_o = 1'b1;
      #7.5 sck_o = 1'b0;
    end
  endtask : dummy

  // pause once sck has settled low, so the fall that starts the bit
  // is still honoured; the stray clocks must be ignored
  task pause();
    #3.5 hold_n_o = 1'b0;
    repeat (3)
    begin
      #7.5 sck_o = 1'b1;
      si_o = ~si_o;
      #7.5 sck_o = 1'b0;
    end
    #7.5 hold_n_o = 1'b1;
    #7.5;
  endtask : pause

  // one byte, msb first; an undriven output reads as unknown
  task xbyte(input logic [7:0] tx, input int hp, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck_o = 1'b0;
      if (i == hp) pause();
      si_o = tx[i];
      #7.5 sck_o = 1'b1;
      rx[i] = so_oe_n_i ? 1'bx : so_i;
      #3 si_o = ~tx[i];
      #4.5;
    end
  endtask : xbyte
endmodule : sfram_spi_master

`default_nettype wire

// ===== sfram_spi_slave.sv
// spi slave front end of a 2k x 8 nonvolatile byte memory
`include "sfram_defs.svh"
`default_nettype none

module sfram_spi_slave (
  // system clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // spi pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // protection and pause pins
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // system side status
  output logic [7:0] status_o,
  output logic update_o
);

  // link side sequencer state
  sfram_pkg::sfram_state_t state_ff; // command phase
  logic [2:0] bit_ff; // bit index inside current byte
  logic [6:0] sh_ff; // first seven bits of the byte
  logic [10:0] addr_ff; // current array location
  logic [2:0] ahi_ff; // useful bits of the high address byte
  logic is_rd_ff; // command is an array read
  logic rd_issue_ff; // a byte must be loaded on the next fall
  logic src_mem_ff; // loaded byte comes from the array

  // link side persistent state
  logic [7:0] stat_ff; // status register
  logic evt_tgl_ff; // toggles on each committed write

  // output shifter, runs on the falling edge
  logic [7:0] out_sh_ff; // bits being returned
  logic drive_ff; // read data is being returned

  // system side
  logic por_ff; // registered reset level sent to the link
  logic por_sync; // reset level seen in the link domain
  logic evt_sync; // synchronised write toggle
  logic evt_seen_ff; // last toggle value handled

  // combinational helpers
  logic [7:0] byte_w; // completed byte, newest bit last
  logic byte_done; // eighth bit arrives on this rise
  logic [10:0] addr_asm; // address from the two address bytes
  logic wel; // write enable latch
  logic ppen; // protect pin enable bit
  logic [1:0] bp; // block protect code
  logic sr_wr_ok; // status write allowed
  logic arr_wr; // array write on this rise
  logic sr_wr; // status write on this rise

  // array port
  sfram_mem_if mport ();

  // byte memory in the link domain
  sfram_mem u_mem (
    .clk_i(sck_i),
    .port(mport.mem)
  );

  // reset level into the link domain; takes effect on sck rises
  sfram_sync u_por_sync (
    .clk_i(sck_i),
    .d_i(por_ff),
    .q_o(por_sync)
  );

  // write event toggle into the system domain
  sfram_sync u_evt_sync (
    .clk_i(mclk_i),
    .d_i(evt_tgl_ff),
    .q_o(evt_sync)
  );

  // msb first: the new bit joins at the bottom
  assign byte_w = {sh_ff, si_i};
  assign byte_done = (bit_ff == `SFRAM_BIT_LAST);
  // top five address bits fall away, only three are kept
  assign addr_asm = {ahi_ff, byte_w};

  // status fields
  assign wel = stat_ff[`SFRAM_SR_WEL];
  assign ppen = stat_ff[`SFRAM_SR_PPEN];
  assign bp = stat_ff[`SFRAM_SR_BP_HI:`SFRAM_SR_BP_LO];

  // protected region check against the block protect code
  function automatic logic blocked(input logic [1:0] code,
                                   input logic [10:0] a);
    logic hit;
    hit = 1'b0;
    unique case (code)
      `SFRAM_BP_QUARTER: hit = (a >= `SFRAM_BASE_QUARTER);
      `SFRAM_BP_HALF: hit = (a >= `SFRAM_BASE_HALF);
      `SFRAM_BP_ALL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : blocked

  // pin protect only counts when the enable bit is one
  assign sr_wr_ok = wel && !(ppen && !wp_n_i);

  // write strobes; a paused or deselected link never writes
  assign arr_wr = !cs_n_i && hold_n_i && byte_done
                  && (state_ff == sfram_pkg::ST_WR)
                  && wel && !blocked(bp, addr_ff);
  assign sr_wr = !cs_n_i && hold_n_i && byte_done
                 && (state_ff == sfram_pkg::ST_SWR) && sr_wr_ok;

  // array port drive
  assign mport.wr_en = arr_wr;
  assign mport.wr_addr = addr_ff;
  assign mport.wr_data = byte_w;
  // first read uses the address just completed, later ones the counter
  assign mport.rd_en = !cs_n_i && hold_n_i && byte_done
                       && (((state_ff == sfram_pkg::ST_ALO) && is_rd_ff)
                       || (state_ff == sfram_pkg::ST_RD));
  assign mport.rd_addr = (state_ff == sfram_pkg::ST_ALO)
                         ? addr_asm : addr_ff;

  // command sequencer on sck rise; select high clears it at once,
  // so every command starts from a fresh select cycle
  always_ff @(posedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      // standby: the sequencer is cleared; only a status reset still loads on sck rises
      state_ff <= sfram_pkg::ST_OPC;
      bit_ff <= 3'h0;
      sh_ff <= 7'h00;
      addr_ff <= 11'h000;
      ahi_ff <= 3'h0;
      is_rd_ff <= 1'b0;
      rd_issue_ff <= 1'b0;
      src_mem_ff <= 1'b0;
    end
    else if (hold_n_i)
    begin
      // pause low skips this edge entirely; state is kept
      sh_ff <= byte_w[6:0];
      bit_ff <= bit_ff + 3'h1;
      rd_issue_ff <= 1'b0;
      if (byte_done)
      begin
        unique case (state_ff)
          sfram_pkg::ST_OPC:
          begin
            // first byte of the cycle is the opcode
            case (byte_w)
              `SFRAM_OP_WREN: state_ff <= sfram_pkg::ST_DONE;
              `SFRAM_OP_WRDI: state_ff <= sfram_pkg::ST_DONE;
              `SFRAM_OP_RDSR:
              begin
                state_ff <= sfram_pkg::ST_SRD;
                rd_issue_ff <= 1'b1;
                src_mem_ff <= 1'b0;
              end
              `SFRAM_OP_WRSR: state_ff <= sfram_pkg::ST_SWR;
              `SFRAM_OP_READ:
              begin
                state_ff <= sfram_pkg::ST_AHI;
                is_rd_ff <= 1'b1;
              end
              `SFRAM_OP_WRITE:
              begin
                state_ff <= sfram_pkg::ST_AHI;
                is_rd_ff <= 1'b0;
              end
              // unknown opcode: deaf until the next select
              default: state_ff <= sfram_pkg::ST_IGN;
            endcase
          end
          sfram_pkg::ST_AHI:
          begin
            // high address byte, only its low three bits matter
            ahi_ff <= byte_w[2:0];
            state_ff <= sfram_pkg::ST_ALO;
          end
          sfram_pkg::ST_ALO:
          begin
            // a read already fetched this location, so step past it
            if (is_rd_ff)
            begin
              addr_ff <= addr_asm + 11'h001;
              rd_issue_ff <= 1'b1;
              src_mem_ff <= 1'b1;
              state_ff <= sfram_pkg::ST_RD;
            end
            else
            begin
              addr_ff <= addr_asm;
              state_ff <= sfram_pkg::ST_WR;
            end
          end
          sfram_pkg::ST_RD:
          begin
            // sequential read, wraps at the top of the array
            addr_ff <= addr_ff + 11'h001;
            rd_issue_ff <= 1'b1;
          end
          sfram_pkg::ST_WR:
          begin
            // address steps past the byte this edge, committed or refused
            addr_ff <= addr_ff + 11'h001;
          end
          sfram_pkg::ST_SRD:
          begin
            // status read repeats while clocks continue
            rd_issue_ff <= 1'b1;
          end
          sfram_pkg::ST_SWR:
          begin
            // one status byte per command; extra bits ignored
            state_ff <= sfram_pkg::ST_DONE;
          end
          sfram_pkg::ST_DONE:
          begin
            // command finished, wait for select to rise
            state_ff <= sfram_pkg::ST_DONE;
          end
          sfram_pkg::ST_IGN:
          begin
            state_ff <= sfram_pkg::ST_IGN;
          end
          // codes outside the enum go deaf until select rises
          default: state_ff <= sfram_pkg::ST_IGN;
        endcase
      end
    end
  end

  // status register on sck rise; kept across select cycles
  always_ff @(posedge sck_i)
  begin
    if (por_sync)
    begin
      // reset only reaches the link when sck moves
      stat_ff <= `SFRAM_SR_RST;
    end
    else if (!cs_n_i && hold_n_i && byte_done)
    begin
      if (state_ff == sfram_pkg::ST_OPC)
      begin
        // latch set and clear commands
        if (byte_w == `SFRAM_OP_WREN)
        begin
          stat_ff[`SFRAM_SR_WEL] <= 1'b1;
        end
        else if (byte_w == `SFRAM_OP_WRDI)
        begin
          stat_ff[`SFRAM_SR_WEL] <= 1'b0;
        end
      end
      else if (sr_wr)
      begin
        // only protect bits change; latch bit keeps its value
        stat_ff <= (byte_w & `SFRAM_SR_WMASK)
                   | (stat_ff & ~`SFRAM_SR_WMASK);
      end
    end
  end

  // event toggle for the system side; data is stable long after
  always_ff @(posedge sck_i)
  begin
    if (por_sync)
    begin
      evt_tgl_ff <= 1'b0;
    end
    else if (arr_wr || sr_wr)
    begin
      evt_tgl_ff <= ~evt_tgl_ff;
    end
  end

  // output shifter on sck fall
  always_ff @(negedge sck_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      out_sh_ff <= 8'h00;
      drive_ff <= 1'b0;
    end
    else if (hold_n_i)
    begin
      if (rd_issue_ff)
      begin
        // new byte, its msb goes out on this fall
        out_sh_ff <= src_mem_ff ? mport.rd_data : stat_ff;
        drive_ff <= 1'b1;
      end
      else
      begin
        out_sh_ff <= {out_sh_ff[6:0], 1'b0};
      end
    end
  end

  // output pin: enable low means driving; pause and select release it
  assign so_o = out_sh_ff[7];
  assign so_oe_n_o = !(drive_ff && !cs_n_i && hold_n_i);

  // system side reset level, registered before crossing
  always_ff @(posedge mclk_i)
  begin
    por_ff <= srst_i;
  end

  // system side write detection and status snapshot
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      evt_seen_ff <= 1'b0;
      update_o <= 1'b0;
      status_o <= `SFRAM_SR_RST;
    end
    else
    begin
      evt_seen_ff <= evt_sync;
      update_o <= (evt_sync != evt_seen_ff);
      if (evt_sync != evt_seen_ff)
      begin
        // stat_ff has been stable since the toggle moved
        status_o <= stat_ff;
      end
    end
  end

endmodule : sfram_spi_slave

`default_nettype wire

// ===== sfram_spi_slave_tb_top.sv
// self-checking bench for the spi memory slave
`include "sfram_defs.svh"
`default_nettype none

module sfram_spi_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0; // system clock
  logic srst = 1'b1; // system reset
  logic wp_n = 1'b1; // write protect pin
  logic sck, cs_n, si, hold_n, so, so_oe_n, update; // pins
  logic [7:0] status; // status snapshot
  logic [7:0] q[$]; // bytes of the next frame
  logic [7:0] sr = 8'h00; // model status without the latch
  logic wel = 1'b0; // model write enable latch
  logic [7:0] snap = 8'h00; // expected status snapshot
  int mem[2048]; // model array, -1 where unknown
  int ta[5] = '{'h3ff, 'h400, 'h5ff, 'h600, 'h7ff}; // protect edges
  int seed = 32'hd13f;
  int upd_cnt = 0;
  int miscompares = 0;
  int compares = 0;

  sfram_spi_slave i_dut (.mclk_i(mclk), .srst_i(srst), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_n_o(so_oe_n),
    .wp_n_i(wp_n), .hold_n_i(hold_n), .status_o(status),
    .update_o(update));
  sfram_spi_master i_mst (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .hold_n_o(hold_n), .so_i(so), .so_oe_n_i(so_oe_n));

  initial
  begin
    forever #20 mclk = ~mclk;
  end

  // pulses may merge, so only presence is judged
  always @(posedge mclk)
  begin
    if (update === 1'b1) upd_cnt++;
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  function automatic bit prot(input int a);
    case (sr[3:2])
      2'h1: return a >= 'h600;
      2'h2: return a >= 'h400;
      2'h3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : prot

  // send q, read nrd bytes, pause before frame bit hp, then judge
  task automatic run(input bit m3, input int nrd, input int hp);
    logic [7:0] rx;
    int a;
    int n0;
    bit cm;
    n0 = upd_cnt;
    cm = 1'b0;
    a = q.size() > 2 ? int'({q[1][2:0], q[2]}) : 0;
    i_mst.sel(m3);
    for (int i = 0; i < q.size() + nrd; i++)
    begin
      i_mst.xbyte(i < q.size() ? q[i] : 8'($random(seed)), hp - 8 * i, rx);
      if (i >= q.size() && q[0] == `SFRAM_OP_RDSR)
        chk(rx, sr | {6'h00, wel, 1'b0});
      if (i >= q.size() && q[0] == `SFRAM_OP_READ)
      begin
        if (mem[a] >= 0) chk(rx, 8'(mem[a]));
        a = (a + 1) % 2048;
      end
    end
    i_mst.desel();
    if (q[0] == `SFRAM_OP_WREN) wel = 1'b1;
    if (q[0] == `SFRAM_OP_WRDI) wel = 1'b0;
    if (q[0] == `SFRAM_OP_WRSR && wel && !(sr[7] && !wp_n))
    begin
      sr = q[1] & 8'h8c;
      cm = 1'b1;
    end
    for (int i = 3; i < q.size() && q[0] == `SFRAM_OP_WRITE; i++)
    begin
      if (wel && !prot(a))
      begin
        mem[a] = q[i];
        cm = 1'b1;
      end
      a = (a + 1) % 2048;
    end
    repeat (10) @(posedge mclk);
    if (q[0] == `SFRAM_OP_WRSR || q[0] == `SFRAM_OP_WRITE)
      chk({7'h00, upd_cnt != n0}, {7'h00, cm});
    if (upd_cnt != n0) snap = sr | {6'h00, wel, 1'b0};
    chk(status, snap);
  endtask : run

  initial
  begin
    foreach (mem[i]) mem[i] = -1;
    // the status register sees reset only through sck
    fork
      i_mst.dummy(4);
      repeat (10) @(posedge mclk);
    join
    #1 srst = 1'b0;
    // the released level must be registered before sck carries it
    repeat (2) @(posedge mclk);
    i_mst.dummy(4);
    repeat (2) @(posedge mclk);
    #1 chk(status, 8'h00);
    q = '{`SFRAM_OP_RDSR};
    run(0, 2, -1);
    q = '{`SFRAM_OP_WRITE, 8'h07, 8'hfe, 8'h3c};
    run(0, 0, -1);
    q = '{`SFRAM_OP_WREN};
    run(1, 0, -1);
    // wrapping burst, junk in the top address bits, paused mid-opcode
    q = '{`SFRAM_OP_WRITE, {5'($random(seed)), 3'h7}, 8'hfe};
    repeat (4) q.push_back(8'($random(seed)));
    run(0, 0, 5);
    q = '{`SFRAM_OP_READ, 8'hff, 8'hfe};
    run(1, 4, 30);
    // each protect code against both sides of every boundary
    for (int bp = 0; bp < 4; bp++)
    begin
      q = '{`SFRAM_OP_WRSR, 8'(bp << 2)};
      run(bp[0], 0, -1);
      foreach (ta[j])
      begin
        q = '{`SFRAM_OP_WRITE, 8'(ta[j] >> 8), 8'(ta[j]), 8'($random(seed))};
        run(0, 0, -1);
        q = '{`SFRAM_OP_READ, 8'(ta[j] >> 8), 8'(ta[j])};
        run(1, 1, -1);
      end
    end
    q = '{`SFRAM_OP_WRSR, 8'h80};
    run(0, 0, -1);
    #1 wp_n = 1'b0;
    q = '{`SFRAM_OP_WRSR, 8'h0c};
    run(1, 0, -1);
    q = '{`SFRAM_OP_RDSR};
    run(0, 1, -1);
    #1 wp_n = 1'b1;
    q = '{`SFRAM_OP_WRSR, 8'h00};
    run(0, 0, -1);
    q = '{`SFRAM_OP_WRDI};
    run(1, 0, -1);
    q = '{`SFRAM_OP_WRITE, 8'h07, 8'hff, 8'h5a};
    run(0, 0, -1);
    q = '{`SFRAM_OP_READ, 8'h07, 8'hff};
    run(0, 1, -1);
    q = '{8'ha5, `SFRAM_OP_WRITE, 8'h07};
    run(0, 2, -1);
    q = '{`SFRAM_OP_RDSR};
    run(1, 1, -1);
    end_sim();
  end
endmodule : sfram_spi_slave_tb_top

`default_nettype wire

// ===== sfram_sync.sv
// two flip-flop level synchroniser
`default_nettype none

module sfram_sync (
  // clock of the receiving domain
  input wire logic clk_i,
  // level from the far domain
  input wire logic d_i,
  // synchronised level
  output logic q_o
);

  logic meta_ff; // first stage, read only by the second

  // plain two stage chain, no reset so no path from the reset net
  always_ff @(posedge clk_i)
  begin
    meta_ff <= d_i;
    q_o <= meta_ff;
  end

endmodule : sfram_sync

`default_nettype wire
